/* common/lpo_consts.svh */
// named constants for the led_output_polarity and output control block
`ifndef LPO_CONSTS_SVH
`define LPO_CONSTS_SVH

`define LPO_ADDR_POLARITY 8'h73
`define LPO_ADDR_HOST_DRIVE 8'h74
`define LPO_ADDR_LINK_TRAN 8'h77
`define LPO_CH_MASK 8'h07
`define LPO_ZERO_BYTE 8'h00
`define LPO_CH_RESET 3'h0
`define LPO_DUTY_FULL 7'h64
`define LPO_PWM_STEPS 100
`define LPO_COUNT_ZERO 7'h00
`define LPO_COUNT_STEP 7'h01

`endif

/* common/lpo_pkg.sv */
// state types for the led_output_polarity and output control block
package lpo_pkg;

  typedef struct packed {
    logic [2:0] polarity;
    logic [2:0] host_drive;
    logic [2:0] link_transition;
    logic [2:0] hold;
    logic [2:0] link_seen;
    logic [2:0] actuated;
    logic mirror_update;
    logic [2:0] mirror_value;
    logic [7:0] rdata;
  } lpo_ctrl_state_t;

  typedef struct packed {
    logic [6:0] count;
  } lpo_timer_state_t;

  typedef struct packed {
    logic level;
    logic oe_n;
  } lpo_pin_state_t;

endpackage

/* logic/lpo_pwm_timer.sv */
// shared pwm period counter for all indicator channels
`timescale 1ns/100ps
`default_nettype none
`include "lpo_consts.svh"

module lpo_pwm_timer #(
  parameter int STEPS = `LPO_PWM_STEPS
) (
  input wire logic core_clk,
  input wire logic reset_n,
  output logic [6:0] count
);

  localparam logic [6:0] LAST = 7'(STEPS - 1);

  lpo_pkg::lpo_timer_state_t state;
  lpo_pkg::lpo_timer_state_t next_state;

  always_comb begin
    next_state = state;
    if (state.count == LAST) begin
      next_state.count = `LPO_COUNT_ZERO;
    end else begin
      next_state.count = state.count + `LPO_COUNT_STEP;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign count = state.count;

endmodule
`default_nettype wire

/* logic/lpo_pin_driver.sv */
// one indicator pin: pwm compare, polarity and output type
`timescale 1ns/100ps
`default_nettype none
`include "lpo_consts.svh"

module lpo_pin_driver (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [6:0] count,
  input wire logic [6:0] duty,
  input wire logic polarity,
  input wire logic push_pull,
  output logic pin_out,
  output logic pin_oe_n
);

  lpo_pkg::lpo_pin_state_t state;
  lpo_pkg::lpo_pin_state_t next_state;
  logic in_duty;
  logic level;

  always_comb begin
    next_state = state;
    // duty is the share of the period spent at the polarity's duty level
    in_duty = (count < duty);
    // inverted drives low inside duty, non-inverted drives high [R3] [R5] [R8] [R9]
    level = polarity ? in_duty : ~in_duty;
    if (push_pull) begin
      next_state.level = level; // [R20]
      next_state.oe_n = 1'h0;
    end else begin
      // open drain: pull low, release for high [R20] [R9]
      next_state.level = 1'h0;
      next_state.oe_n = level;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '{level: 1'h0, oe_n: 1'h1};
    end else begin
      state <= next_state;
    end
  end

  assign pin_out = state.level;
  assign pin_oe_n = state.oe_n;

endmodule
`default_nettype wire

/* logic/lpo_output_control.sv */
// led_output_polarity, host drive and linked transition control for three channels
//
// How it works
// R1: polarity write copies bits into mirror unless block mirror sync set.
// R2: on a linked channel a touch counts as host drive one.
// R3: inverted polarity: duty is the share of time pin is low.
// R4: inverted idle uses minimum duty; breathe ramps minimum to maximum.
// R5: non-inverted: duty is time high; idle sits at hundred minus minimum.
// R6: non-inverted breathe ramps hundred minus min to hundred minus max.
// R7: mirror bits shape duty mapping only, never the pin level directly.
// R8: polarity zero inverts, host drive one pulls pin low.
// R9: polarity one: drive one sets pin high or released when open drain.
// R10: polarity bits 2,1,0 serve channels three, two, one.
// R11: host drive bit ignored while its channel is linked.
// R12: polarity sets idle pin state; behaviour mode sets actuated behaviour.
// R13: drive zero idles at minimum duty; one actuates, maximum when direct.
// R14: non-inverted actuated direct at hundred minus max; breathe peaks at min.
// R15: inverted idle ignores maximum duty, led stays on at minimum.
// R16: transition bit zero: linking untouched host-driven channel changes state.
// R17: transition one, inverted link one: link keeps state, touch changes it.
// R18: transition one, inverted link zero: link keeps state, touches ignored.
// R19: software sets inverted link transition when using breathe or pulse.
// R20: output type zero open drain, one push-pull.
// R21: mirror one takes duty relative to hundred, zero relative to zero.
// R22: bits 7 to 3 read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none
`include "lpo_consts.svh"

module lpo_output_control #(
  parameter int PWM_STEPS = `LPO_PWM_STEPS
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] link_enable,
  input wire logic [2:0] touch_detected,
  input wire logic [2:0] output_type,
  input wire logic [2:0] mirror_enable,
  input wire logic [2:0] behaviour_direct,
  input wire logic block_polarity_mirror_sync,
  input wire logic inverted_link_transition,
  input wire logic [6:0] min_duty_ch1,
  input wire logic [6:0] min_duty_ch2,
  input wire logic [6:0] min_duty_ch3,
  input wire logic [6:0] max_duty_ch1,
  input wire logic [6:0] max_duty_ch2,
  input wire logic [6:0] max_duty_ch3,
  input wire logic [6:0] ramp_duty_ch1,
  input wire logic [6:0] ramp_duty_ch2,
  input wire logic [6:0] ramp_duty_ch3,
  output logic indicator_output_1,
  output logic indicator_output_1_oe_n,
  output logic indicator_output_2,
  output logic indicator_output_2_oe_n,
  output logic indicator_output_3,
  output logic indicator_output_3_oe_n,
  output logic [2:0] channel_actuated,
  output logic mirror_update,
  output logic [2:0] mirror_value
);

  lpo_pkg::lpo_ctrl_state_t state;
  lpo_pkg::lpo_ctrl_state_t next_state;

  logic [6:0] pwm_count;
  logic [6:0] min_duty [3];
  logic [6:0] max_duty [3];
  logic [6:0] ramp_duty [3];
  logic [6:0] duty [3];
  logic [2:0] pin_level;
  logic [2:0] pin_oe_n;
  logic [2:0] link_rise;
  logic [2:0] next_hold;
  logic [2:0] act;

  // limit a setting to the full scale
  function automatic logic [6:0] clip_duty(input logic [6:0] d);
    clip_duty = (d > `LPO_DUTY_FULL) ? `LPO_DUTY_FULL : d;
  endfunction

  // settings taken relative to hundred when mirrored
  function automatic logic [6:0] mirror_duty(input logic [6:0] d, input logic m);
    mirror_duty = m ? (`LPO_DUTY_FULL - clip_duty(d)) : clip_duty(d);
  endfunction

  // keep only the three channel bits of a register byte
  function automatic logic [2:0] ch_bits(input logic [7:0] b);
    ch_bits = 3'(b & `LPO_CH_MASK);
  endfunction

  assign min_duty[0] = min_duty_ch1;
  assign min_duty[1] = min_duty_ch2;
  assign min_duty[2] = min_duty_ch3;
  assign max_duty[0] = max_duty_ch1;
  assign max_duty[1] = max_duty_ch2;
  assign max_duty[2] = max_duty_ch3;
  assign ramp_duty[0] = ramp_duty_ch1;
  assign ramp_duty[1] = ramp_duty_ch2;
  assign ramp_duty[2] = ramp_duty_ch3;

  // actuation source per channel, with linked transition hold
  always_comb begin
    link_rise = link_enable & ~state.link_seen;
    next_hold = state.hold;
    act = '0;
    for (int i = 0; i < 3; i++) begin
      if (!link_enable[i]) begin
        next_hold[i] = 1'h0;
      end else if (link_rise[i] && state.host_drive[i] && !touch_detected[i]) begin
        // host-actuated channel just linked with no touch [R16] [R17] [R18]
        next_hold[i] = state.link_transition[i];
      end
      if (!link_enable[i]) begin
        act[i] = state.host_drive[i]; // [R11] [R13]
      end else if (next_hold[i]) begin
        // held on; a touch toggles it only with inverted link [R17] [R18]
        act[i] = inverted_link_transition ? ~touch_detected[i] : 1'h1;
      end else begin
        act[i] = touch_detected[i]; // [R2] [R11] [R16]
      end
    end
  end

  // duty selection: idle min, direct max, else engine ramp [R4] [R12] [R13] [R15]
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!state.actuated[i]) begin
        duty[i] = mirror_duty(min_duty[i], mirror_enable[i]); // [R4] [R5] [R15] [R21]
      end else if (behaviour_direct[i]) begin
        duty[i] = mirror_duty(max_duty[i], mirror_enable[i]); // [R13] [R14] [R21]
      end else begin
        // engine ramps between min and max; mirror flips the scale [R6] [R7] [R14]
        duty[i] = mirror_duty(ramp_duty[i], mirror_enable[i]); // [R4] [R21]
      end
    end
  end

  always_comb begin
    next_state = state;
    next_state.mirror_update = 1'h0;
    next_state.hold = next_hold;
    next_state.link_seen = link_enable;
    next_state.actuated = act;
    if (reg_wr) begin
      unique case (reg_addr)
        `LPO_ADDR_POLARITY: begin
          next_state.polarity = ch_bits(reg_wdata); // [R10] [R22]
          if (!block_polarity_mirror_sync) begin
            next_state.mirror_update = 1'h1; // [R1]
            next_state.mirror_value = ch_bits(reg_wdata); // [R1]
          end
        end
        `LPO_ADDR_HOST_DRIVE: begin
          next_state.host_drive = ch_bits(reg_wdata); // [R13] [R22]
        end
        `LPO_ADDR_LINK_TRAN: begin
          next_state.link_transition = ch_bits(reg_wdata); // [R22]
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `LPO_ADDR_POLARITY: next_state.rdata = {5'h00, state.polarity}; // [R22]
        `LPO_ADDR_HOST_DRIVE: next_state.rdata = {5'h00, state.host_drive}; // [R22]
        `LPO_ADDR_LINK_TRAN: next_state.rdata = {5'h00, state.link_transition}; // [R22]
        default: next_state.rdata = `LPO_ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  lpo_pwm_timer #(
    .STEPS(PWM_STEPS)
  ) u_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .count(pwm_count)
  );

  for (genvar g = 0; g < 3; g++) begin : g_pin
    lpo_pin_driver u_pin (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .count(pwm_count),
      .duty(duty[g]),
      .polarity(state.polarity[g]),
      .push_pull(output_type[g]),
      .pin_out(pin_level[g]),
      .pin_oe_n(pin_oe_n[g])
    );
  end

  assign indicator_output_1 = pin_level[0];
  assign indicator_output_2 = pin_level[1];
  assign indicator_output_3 = pin_level[2];
  assign indicator_output_1_oe_n = pin_oe_n[0];
  assign indicator_output_2_oe_n = pin_oe_n[1];
  assign indicator_output_3_oe_n = pin_oe_n[2];
  assign reg_rdata = state.rdata;
  assign channel_actuated = state.actuated;
  assign mirror_update = state.mirror_update;
  assign mirror_value = state.mirror_value;

endmodule
`default_nettype wire

/* bench/lpo_output_control_sva.sv */
// assertion checker for the led_output_polarity and output control block
`timescale 1ns/100ps
`default_nettype none
module lpo_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] link_enable,
  input wire logic [2:0] touch_detected,
  input wire logic [2:0] output_type,
  input wire logic [2:0] mirror_enable,
  input wire logic block_polarity_mirror_sync,
  input wire logic inverted_link_transition,
  input wire logic [6:0] min_duty_ch1,
  input wire logic [6:0] max_duty_ch1,
  input wire logic [6:0] ramp_duty_ch1,
  input wire logic indicator_output_1,
  input wire logic indicator_output_1_oe_n,
  input wire logic [2:0] channel_actuated,
  input wire logic mirror_update,
  input wire logic [2:0] mirror_value
);
  logic pol;
  logic pw;
  logic d_full;
  logic d_zero;
  assign pw = reg_wr && reg_addr == 8'h73;
  assign d_full = {min_duty_ch1, max_duty_ch1, ramp_duty_ch1} == {3{7'h64}};
  assign d_zero = {min_duty_ch1, max_duty_ch1, ramp_duty_ch1} == 21'h0;
  // shadow of channel one polarity
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pol <= 1'b0;
    end else if (pw) begin
      pol <= reg_wdata[0];
    end
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  chk_mirror_copy: assert property (
    pw && !block_polarity_mirror_sync |=>
    mirror_update && mirror_value == $past(reg_wdata[2:0])) else $error("mirror not copied");
  chk_mirror_block: assert property (
    pw && block_polarity_mirror_sync |=> !mirror_update) else $error("mirror not blocked");
  chk_touch_act: assert property (
    link_enable[0] && touch_detected[0] && !inverted_link_transition |=> channel_actuated[0])
    else $error("touch not actuating");
  chk_od_low: assert property (
    !output_type[0] [*2] |=> !indicator_output_1) else $error("open drain drives high");
  chk_pp_drive: assert property (
    output_type[0] [*2] |=> !indicator_output_1_oe_n) else $error("push pull released");
  chk_full_level: assert property (
    (d_full && !mirror_enable[0] && output_type[0] && !pw) [*3] |=> indicator_output_1 == pol)
    else $error("full duty level wrong");
  chk_zero_level: assert property (
    (d_zero && !mirror_enable[0] && output_type[0] && !pw) [*3] |=> indicator_output_1 != pol)
    else $error("zero duty level wrong");
  chk_read_mask: assert property (
    reg_rd |=> reg_rdata[7:3] == 5'h00) else $error("upper bits not zero");
  cov_mirror: cover property (mirror_update);
  cov_link: cover property (link_enable[0] && channel_actuated[0]);
  cov_od: cover property (!indicator_output_1_oe_n && !output_type[0]);
endmodule
bind lpo_output_control lpo_chk u_lpo_chk (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .link_enable(link_enable),
  .touch_detected(touch_detected),
  .output_type(output_type),
  .mirror_enable(mirror_enable),
  .block_polarity_mirror_sync(block_polarity_mirror_sync),
  .inverted_link_transition(inverted_link_transition),
  .min_duty_ch1(min_duty_ch1),
  .max_duty_ch1(max_duty_ch1),
  .ramp_duty_ch1(ramp_duty_ch1),
  .indicator_output_1(indicator_output_1),
  .indicator_output_1_oe_n(indicator_output_1_oe_n),
  .channel_actuated(channel_actuated),
  .mirror_update(mirror_update),
  .mirror_value(mirror_value)
);
`default_nettype wire

/* bench/tb_lpo_output_control.sv */
// self-checking bench for the led_output_polarity and output control block
`timescale 1ns/100ps
`default_nettype none
module tb_lpo_output_control;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [2:0] link_enable = 3'h0;
  logic [2:0] touch_detected = 3'h0;
  logic [2:0] output_type = 3'h7;
  logic [2:0] mirror_enable = 3'h0;
  logic [2:0] behaviour_direct = 3'h7;
  logic block_polarity_mirror_sync = 1'b0;
  logic inverted_link_transition = 1'b0;
  logic [6:0] min_duty_ch1 = 7'h00;
  logic [6:0] min_duty_ch2 = 7'h00;
  logic [6:0] min_duty_ch3 = 7'h00;
  logic [6:0] max_duty_ch1 = 7'h00;
  logic [6:0] max_duty_ch2 = 7'h00;
  logic [6:0] max_duty_ch3 = 7'h00;
  logic [6:0] ramp_duty_ch1 = 7'h00;
  logic [6:0] ramp_duty_ch2 = 7'h00;
  logic [6:0] ramp_duty_ch3 = 7'h00;
  logic [7:0] reg_rdata;
  logic indicator_output_1, indicator_output_2, indicator_output_3;
  logic indicator_output_1_oe_n, indicator_output_2_oe_n, indicator_output_3_oe_n;
  logic [2:0] channel_actuated;
  logic mirror_update;
  logic [2:0] mirror_value;
  logic [7:0] adr [3] = '{8'h73, 8'h74, 8'h77};
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  lpo_output_control u_lpo_output_control (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .link_enable(link_enable),
    .touch_detected(touch_detected),
    .output_type(output_type),
    .mirror_enable(mirror_enable),
    .behaviour_direct(behaviour_direct),
    .block_polarity_mirror_sync(block_polarity_mirror_sync),
    .inverted_link_transition(inverted_link_transition),
    .min_duty_ch1(min_duty_ch1),
    .min_duty_ch2(min_duty_ch2),
    .min_duty_ch3(min_duty_ch3),
    .max_duty_ch1(max_duty_ch1),
    .max_duty_ch2(max_duty_ch2),
    .max_duty_ch3(max_duty_ch3),
    .ramp_duty_ch1(ramp_duty_ch1),
    .ramp_duty_ch2(ramp_duty_ch2),
    .ramp_duty_ch3(ramp_duty_ch3),
    .indicator_output_1(indicator_output_1),
    .indicator_output_1_oe_n(indicator_output_1_oe_n),
    .indicator_output_2(indicator_output_2),
    .indicator_output_2_oe_n(indicator_output_2_oe_n),
    .indicator_output_3(indicator_output_3),
    .indicator_output_3_oe_n(indicator_output_3_oe_n),
    .channel_actuated(channel_actuated),
    .mirror_update(mirror_update),
    .mirror_value(mirror_value)
  );
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1;
    chk(reg_rdata, e);
  endtask
  // link, touch and link mode, then the actuation state
  task automatic lt(input logic [2:0] lk, input logic [2:0] tc, input logic iv, input logic [7:0] e);
    @(posedge core_clk);
    link_enable <= lk;
    touch_detected <= tc;
    inverted_link_transition <= iv;
    wt(3);
    chk({5'h00, channel_actuated}, e);
  endtask
  task automatic dty(input logic [6:0] mn, input logic [6:0] mx, input logic [6:0] rp);
    @(posedge core_clk);
    {min_duty_ch1, min_duty_ch2, min_duty_ch3} <= {3{mn}};
    {max_duty_ch1, max_duty_ch2, max_duty_ch3} <= {3{mx}};
    {ramp_duty_ch1, ramp_duty_ch2, ramp_duty_ch3} <= {3{rp}};
  endtask
  // low cycles of every channel over one full period
  task automatic meas(input logic od, input logic [7:0] e);
    int n [3];
    logic [2:0] v;
    n = '{0, 0, 0};
    wt(6);
    for (int i = 0; i < 100; i++) begin
      if (od) begin
        v = {indicator_output_3_oe_n, indicator_output_2_oe_n, indicator_output_1_oe_n};
      end else begin
        v = {indicator_output_3, indicator_output_2, indicator_output_1};
      end
      for (int c = 0; c < 3; c++) begin
        if (v[c] === 1'h0) n[c]++;
      end
      wt(1);
    end
    for (int c = 0; c < 3; c++) begin
      chk(8'(n[c]), e);
    end
  endtask
  task automatic t_regs;
    for (int i = 0; i < 3; i++) begin
      rd(adr[i], 8'h00);
      wr(adr[i], 8'hff);
      rd(adr[i], 8'h07);
      wr(adr[i], 8'h00);
    end
    rd(8'h75, 8'h00);
  endtask
  task automatic t_mirror;
    wr(8'h73, 8'h02);
    chk({mirror_update, 4'h0, mirror_value}, 8'h82);
    @(posedge core_clk);
    block_polarity_mirror_sync <= 1'h1;
    wr(8'h73, 8'h05);
    chk({mirror_update, 4'h0, mirror_value}, 8'h02);
    @(posedge core_clk);
    block_polarity_mirror_sync <= 1'h0;
  endtask
  task automatic t_link;
    wr(8'h74, 8'h07);
    lt(3'h0, 3'h0, 1'b0, 8'h07);
    lt(3'h7, 3'h0, 1'b0, 8'h00);
    lt(3'h7, 3'h7, 1'b0, 8'h07);
    lt(3'h0, 3'h0, 1'b0, 8'h07);
    wr(8'h77, 8'h03);
    lt(3'h7, 3'h0, 1'b0, 8'h03);
    lt(3'h7, 3'h7, 1'b0, 8'h07);
    lt(3'h0, 3'h0, 1'b1, 8'h07);
    lt(3'h7, 3'h0, 1'b1, 8'h03);
    lt(3'h7, 3'h7, 1'b1, 8'h04);
    wr(8'h74, 8'h00);
    lt(3'h0, 3'h0, 1'b0, 8'h00);
  endtask
  task automatic t_pwm;
    wr(8'h73, 8'h00);
    dty(7'h1e, 7'h3c, 7'h32);
    meas(1'b0, 8'h1e);
    wr(8'h74, 8'h07);
    meas(1'h0, 8'h3c);
    @(posedge core_clk);
    behaviour_direct <= 3'h0;
    inverted_link_transition <= 1'h1;
    meas(1'h0, 8'h32);
    @(posedge core_clk);
    behaviour_direct <= 3'h7;
    wr(8'h73, 8'h07);
    meas(1'h0, 8'h28);
    @(posedge core_clk);
    behaviour_direct <= 3'h0;
    meas(1'h0, 8'h32);
    @(posedge core_clk);
    behaviour_direct <= 3'h7;
    wr(8'h74, 8'h00);
    meas(1'h0, 8'h46);
    @(posedge core_clk);
    mirror_enable <= 3'h7;
    meas(1'h0, 8'h1e);
    @(posedge core_clk);
    mirror_enable <= 3'h0;
    output_type <= 3'h0;
    meas(1'h1, 8'h46);
    @(posedge core_clk);
    output_type <= 3'h7;
    dty(7'h64, 7'h64, 7'h64);
    meas(1'h0, 8'h00);
    wr(8'h73, 8'h00);
    meas(1'h0, 8'h64);
    dty(7'h00, 7'h00, 7'h00);
    meas(1'h0, 8'h00);
    @(posedge core_clk);
    mirror_enable <= 3'h7;
    meas(1'h0, 8'h64);
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      give_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs;
    t_mirror;
    t_link;
    t_pwm;
    give_verdict;
  end
endmodule
`default_nettype wire
